// *** hdl/cag_addr_gen.sv ***
// What this block does
// - Sequential flow advances the program counter by the instruction byte length.
// - Relative target is next address plus sign-extended 8-bit displacement.
// - Short branch and all conditional branches use the relative target.
// - Immediate branch loads a 16-bit target, short fixed call an 11-bit one.
// - Table call selects an entry by immediate bits 1 to 5 and loads it.
// - Register jump copies the accumulator pair into the program counter.
// - Unsigned multiply stores accumulator times named register into accumulator pair.
// - Unsigned word divide reads and writes the accumulator pair implicitly.
// - Decimal adjust and digit rotate work on the accumulator implicitly.
// - Register operands come from the bank chosen by the two select flags.
// - Each bank holds eight byte registers forming four 16-bit pairs.
// - Direct addressing uses the 16-bit immediate as operand address.
// - Short direct addressing reaches the 256-byte window FE20H to FF1FH.
// - Short direct bit 8 is set for immediates 00H to 1FH, else cleared.
// - Short direct 16-bit form accepts even addresses only.
// - Special register addressing maps onto FF00H-FFCFH and FFE0H-FFFFH.
// - Special register 16-bit form accepts even addresses only.
// - Register indirect uses the named pair of the selected bank.
// - Based addressing adds zero-extended offset to the base pair, carry dropped.
`default_nettype none
module cag_addr_gen #(
    parameter logic [15:0] RESET_PC = 16'h0000,
    parameter logic [15:0] TABLE_BASE = 16'h0000,
    parameter logic [15:0] FIXED_CALL_BASE = 16'h0000
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_bank_select_low,
    input wire logic i_bank_select_high,
    input wire cag_pkg::cag_branch_t i_branch,
    output logic o_branch_ready,
    output logic o_table_req,
    output logic [15:0] o_table_addr,
    input wire logic i_table_valid,
    input wire logic [15:0] i_table_data,
    output logic [15:0] o_program_counter,
    input wire cag_pkg::cag_operand_t i_operand,
    output logic o_operand_valid,
    output cag_pkg::cag_result_t o_operand_result,
    input wire cag_pkg::cag_implied_t i_implied,
    input wire cag_pkg::cag_reg_write_t i_reg_write,
    output logic [7:0] o_accumulator
);
    import cag_pkg::*;

    typedef enum logic {
        S_RUN, S_TABLE
    } cag_state_t;

    localparam int NUM_REGS = NUM_BANKS * REGS_PER_BANK;

    function automatic logic [REG_IDX_W-1:0] byte_idx(input logic [1:0] bank,
                                                      input logic [2:0] sel);
        byte_idx = {bank, sel};
    endfunction

    function automatic logic [REG_IDX_W-1:0] pair_idx(input logic [1:0] bank,
                                                      input logic [1:0] pair);
        pair_idx = {bank, pair, 1'b0};
    endfunction

    logic [7:0] regs_reg [NUM_REGS];
    logic [7:0] regs_next [NUM_REGS];
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [15:0] table_addr_reg;
    logic [15:0] table_addr_next;
    cag_state_t state_reg;
    cag_state_t state_next;
    logic op_valid_reg;
    cag_result_t op_result_reg;
    cag_result_t op_result_next;

    wire [1:0] bank = {i_bank_select_high, i_bank_select_low};

    // Pair reads index the array in the expression itself.
    // A register write then re-evaluates them at once, with no stale pair value.
    wire [4:0] ax_lo = pair_idx(bank, AX_PAIR);
    wire [4:0] ax_hi = ax_lo + 5'h01;
    wire [4:0] hl_lo = pair_idx(bank, HL_PAIR);
    wire [4:0] hl_hi = hl_lo + 5'h01;
    wire [7:0] acc_val = regs_reg[byte_idx(bank, A_IDX)];
    wire [15:0] ax_val = {regs_reg[ax_hi], regs_reg[ax_lo]};
    wire [15:0] hl_val = {regs_reg[hl_hi], regs_reg[hl_lo]};

    // Branch target selection.
    wire branch_take = i_branch.valid && (state_reg == S_RUN);
    wire [15:0] seq_addr = pc_reg + {13'h0000, i_branch.length};
    wire [15:0] disp_ext = {{8{i_branch.operand[DISP_SIGN_BIT]}}, i_branch.operand[7:0]};
    wire [15:0] rel_addr = seq_addr + disp_ext;
    wire [15:0] fixed_addr = FIXED_CALL_BASE | {5'h00, i_branch.operand[10:0]};
    wire [4:0] table_sel = i_branch.operand[TABLE_SEL_MSB:TABLE_SEL_LSB];
    wire [15:0] table_addr = TABLE_BASE | {10'h000, table_sel, 1'b0};

    always_comb begin
        pc_next = pc_reg;
        state_next = state_reg;
        table_addr_next = table_addr_reg;
        if (state_reg == S_TABLE) begin
            if (i_table_valid) begin
                pc_next = i_table_data;
                state_next = S_RUN;
            end
        end else if (branch_take) begin
            unique case (i_branch.kind)
                BR_SEQ: pc_next = seq_addr;
                BR_REL: pc_next = rel_addr;
                BR_IMM16: pc_next = i_branch.operand;
                BR_IMM11: pc_next = fixed_addr;
                BR_TABLE: begin
                    table_addr_next = table_addr;
                    state_next = S_TABLE;
                end
                BR_REG: pc_next = ax_val;
                default: pc_next = pc_reg;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pc_reg <= RESET_PC;
            state_reg <= S_RUN;
            table_addr_reg <= 16'h0000;
        end else begin
            pc_reg <= pc_next;
            state_reg <= state_next;
            table_addr_reg <= table_addr_next;
        end
    end

    assign o_branch_ready = (state_reg == S_RUN);
    assign o_table_req = (state_reg == S_TABLE);
    assign o_table_addr = table_addr_reg;
    assign o_program_counter = pc_reg;

    // Operand address generation.
    wire [7:0] imm8 = i_operand.operand[7:0];
    wire saddr_bit8 = (imm8 < SADDR_SFR_LIMIT);
    wire [15:0] saddr_addr = {SADDR_PAGE_TOP, saddr_bit8, imm8};
    wire [15:0] sfr_addr = {SFR_PAGE, imm8};
    wire sfr_gap = (imm8 >= SFR_GAP_LO) && (imm8 <= SFR_GAP_HI);
    wire odd_wide = i_operand.wide && imm8[0];
    wire [7:0] reg_byte = regs_reg[byte_idx(bank, i_operand.sel)];
    wire [4:0] rp_lo = pair_idx(bank, i_operand.sel[1:0]);
    wire [4:0] rp_hi = rp_lo + 5'h01;
    wire [15:0] reg_pair = {regs_reg[rp_hi], regs_reg[rp_lo]};
    wire [15:0] based_addr = hl_val + {8'h00, imm8};

    always_comb begin
        op_result_next = '0;
        unique case (i_operand.mode)
            OP_IMPLIED: begin
                op_result_next.is_reg = 1'b1;
                op_result_next.data = i_operand.wide ? ax_val : {8'h00, acc_val};
            end
            OP_REGISTER: begin
                op_result_next.is_reg = 1'b1;
                op_result_next.data = i_operand.wide ? reg_pair : {8'h00, reg_byte};
            end
            OP_DIRECT: op_result_next.addr = i_operand.operand;
            OP_SHORT: begin
                op_result_next.addr = saddr_addr;
                op_result_next.fault = odd_wide;
            end
            OP_SFR: begin
                op_result_next.addr = sfr_addr;
                op_result_next.fault = odd_wide || sfr_gap;
            end
            OP_INDIRECT: op_result_next.addr = reg_pair;
            OP_BASED: op_result_next.addr = based_addr;
            default: op_result_next = '0;
        endcase
    end

    // All addresses held as 16-bit values.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            op_valid_reg <= 1'b0;
            op_result_reg <= '0;
        end else begin
            op_valid_reg <= i_operand.valid;
            op_result_reg <= i_operand.valid ? op_result_next : op_result_reg;
        end
    end

    assign o_operand_valid = op_valid_reg;
    assign o_operand_result = op_result_reg;
    assign o_accumulator = acc_val;

    // Implied arithmetic and register write-back.
    wire [7:0] imp_src = regs_reg[byte_idx(bank, i_implied.sel)];
    wire imp_mul = i_implied.valid && (i_implied.op == IMP_MULTIPLY);
    wire imp_div = i_implied.valid && (i_implied.op == IMP_DIVIDE);
    wire imp_acc = i_implied.valid && (i_implied.op == IMP_ACCUM);
    wire [15:0] product = {8'h00, acc_val} * {8'h00, imp_src};
    wire div_zero = (imp_src == 8'h00);
    wire [15:0] quotient = div_zero ? DIV_ZERO_QUOT : ax_val / {8'h00, imp_src};
    wire [15:0] rem_full = div_zero ? ax_val : ax_val % {8'h00, imp_src};
    // The general write port yields to implied results so one cycle never mixes both.
    wire port_wr = i_reg_write.valid && !i_implied.valid;
    wire wr_pair_en = imp_mul || imp_div || (port_wr && i_reg_write.wide);
    wire [4:0] wr_pair_lo = (imp_mul || imp_div) ? pair_idx(bank, AX_PAIR)
                                                 : pair_idx(bank, i_reg_write.sel[1:0]);
    wire [15:0] wr_pair_val = imp_mul ? product : imp_div ? quotient : i_reg_write.data;
    wire wr_byte_en = imp_acc || imp_div || (port_wr && !i_reg_write.wide);
    wire [4:0] wr_byte_idx = imp_acc ? byte_idx(bank, A_IDX)
                           : imp_div ? byte_idx(bank, i_implied.sel)
                           : byte_idx(bank, i_reg_write.sel);
    wire [7:0] wr_byte_val = imp_acc ? i_implied.value
                           : imp_div ? rem_full[7:0] : i_reg_write.data[7:0];

    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
            localparam logic [4:0] GI = 5'(g);
            wire hit_lo = wr_pair_en && (wr_pair_lo == GI);
            wire hit_hi = wr_pair_en && ((wr_pair_lo + 5'h01) == GI);
            wire hit_byte = wr_byte_en && (wr_byte_idx == GI);
            assign regs_next[g] = hit_lo ? wr_pair_val[7:0]
                                : hit_hi ? wr_pair_val[15:8]
                                : hit_byte ? wr_byte_val : regs_reg[g];
            always_ff @(posedge i_clock) begin
                if (!i_reset_n) begin
                    regs_reg[g] <= 8'h00;
                end else begin
                    regs_reg[g] <= regs_next[g];
                end
            end
        end
    endgenerate

    property p_seq_advance;
        @(posedge i_clock) disable iff (!i_reset_n)
        (branch_take && i_branch.kind == BR_SEQ)
            |=> pc_reg == 16'($past(pc_reg) + {13'h0000, $past(i_branch.length)});
    endproperty
    a_seq_advance: assert property (p_seq_advance)
        else $error("Sequential advance wrong.");

    property p_rel_target;
        @(posedge i_clock) disable iff (!i_reset_n)
        (branch_take && i_branch.kind == BR_REL)
            |=> pc_reg == 16'($past(pc_reg) + {13'h0000, $past(i_branch.length)}
                + {{8{$past(i_branch.operand[7])}}, $past(i_branch.operand[7:0])});
    endproperty
    a_rel_target: assert property (p_rel_target)
        else $error("Relative target wrong.");

    property p_imm_target;
        @(posedge i_clock) disable iff (!i_reset_n)
        (branch_take && i_branch.kind == BR_IMM16) |=> pc_reg == $past(i_branch.operand);
    endproperty
    a_imm_target: assert property (p_imm_target)
        else $error("Immediate target wrong.");

    property p_table_flow;
        @(posedge i_clock) disable iff (!i_reset_n)
        (branch_take && i_branch.kind == BR_TABLE)
            |=> o_table_req && !o_branch_ready
                && o_table_addr[5:1] == $past(i_branch.operand[5:1]);
    endproperty
    a_table_flow: assert property (p_table_flow)
        else $error("Table call request wrong.");

    property p_table_load;
        @(posedge i_clock) disable iff (!i_reset_n)
        (o_table_req && i_table_valid) |=> pc_reg == $past(i_table_data) && o_branch_ready;
    endproperty
    a_table_load: assert property (p_table_load)
        else $error("Table destination not loaded.");

    property p_reg_jump;
        @(posedge i_clock) disable iff (!i_reset_n)
        (branch_take && i_branch.kind == BR_REG) |=> pc_reg == $past(ax_val);
    endproperty
    a_reg_jump: assert property (p_reg_jump)
        else $error("Register jump target wrong.");

    property p_multiply;
        @(posedge i_clock) disable iff (!i_reset_n)
        (imp_mul && $stable(bank)) ##1 $stable(bank)
            |-> ax_val == {8'h00, $past(acc_val)} * {8'h00, $past(imp_src)};
    endproperty
    a_multiply: assert property (p_multiply)
        else $error("Product not in accumulator pair.");

    property p_short_page;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_operand.valid && i_operand.mode == OP_SHORT)
            |=> o_operand_valid && o_operand_result.addr[8] == ($past(imm8) < 8'h20)
                && o_operand_result.addr[15:9] == 7'h7F;
    endproperty
    a_short_page: assert property (p_short_page)
        else $error("Short direct page bit wrong.");

    property p_sfr_map;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_operand.valid && i_operand.mode == OP_SFR)
            |=> o_operand_result.addr[15:8] == 8'hFF
                && o_operand_result.fault == ($past(odd_wide) || $past(sfr_gap));
    endproperty
    a_sfr_map: assert property (p_sfr_map)
        else $error("Special register mapping wrong.");

    property p_based;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_operand.valid && i_operand.mode == OP_BASED)
            |=> o_operand_result.addr == 16'($past(hl_val) + {8'h00, $past(imm8)});
    endproperty
    a_based: assert property (p_based)
        else $error("Based address wrong.");

    property p_divide;
        @(posedge i_clock) disable iff (!i_reset_n)
        (imp_div && !div_zero && $stable(bank)) ##1 $stable(bank)
            |-> ax_val == $past(ax_val) / {8'h00, $past(imp_src)};
    endproperty
    a_divide: assert property (p_divide)
        else $error("Quotient not in accumulator pair.");

    property p_direct;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_operand.valid && i_operand.mode == OP_DIRECT)
            |=> o_operand_result.addr == $past(i_operand.operand)
                && !o_operand_result.fault && !o_operand_result.is_reg;
    endproperty
    a_direct: assert property (p_direct)
        else $error("Direct address wrong.");

    property p_indirect;
        @(posedge i_clock) disable iff (!i_reset_n)
        (i_operand.valid && i_operand.mode == OP_INDIRECT)
            |=> o_operand_valid && o_operand_result.addr == $past(reg_pair);
    endproperty
    a_indirect: assert property (p_indirect)
        else $error("Register indirect address wrong.");
endmodule
`default_nettype wire

// *** common/cag_pkg.sv ***
`default_nettype none
package cag_pkg;
    localparam int ADDR_W = 16;
    localparam int NUM_BANKS = 4;
    localparam int REGS_PER_BANK = 8;
    localparam int REG_IDX_W = 5;
    localparam logic [2:0] X_IDX = 3'h0;
    localparam logic [2:0] A_IDX = 3'h1;
    localparam logic [1:0] AX_PAIR = 2'h0;
    localparam logic [1:0] HL_PAIR = 2'h3;
    localparam int DISP_SIGN_BIT = 7;
    localparam int TABLE_SEL_LSB = 1;
    localparam int TABLE_SEL_MSB = 5;
    localparam logic [7:0] SADDR_SFR_LIMIT = 8'h20;
    localparam logic [6:0] SADDR_PAGE_TOP = 7'h7F;
    localparam logic [7:0] SFR_PAGE = 8'hFF;
    localparam logic [7:0] SFR_GAP_LO = 8'hD0;
    localparam logic [7:0] SFR_GAP_HI = 8'hDF;
    localparam logic [15:0] DIV_ZERO_QUOT = 16'hFFFF;
    typedef enum logic [2:0] {
        BR_SEQ, BR_REL, BR_IMM16, BR_IMM11, BR_TABLE, BR_REG
    } cag_branch_kind_t;
    typedef enum logic [2:0] {
        OP_IMPLIED, OP_REGISTER, OP_DIRECT, OP_SHORT, OP_SFR, OP_INDIRECT, OP_BASED
    } cag_operand_mode_t;
    typedef enum logic [1:0] {
        IMP_MULTIPLY, IMP_DIVIDE, IMP_ACCUM
    } cag_implied_op_t;
    typedef struct packed {
        logic valid;
        cag_branch_kind_t kind;
        logic [2:0] length;
        logic [15:0] operand;
    } cag_branch_t;
    typedef struct packed {
        logic valid;
        cag_operand_mode_t mode;
        logic wide;
        logic [2:0] sel;
        logic [15:0] operand;
    } cag_operand_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic is_reg;
        logic fault;
    } cag_result_t;
    typedef struct packed {
        logic valid;
        cag_implied_op_t op;
        logic [2:0] sel;
        logic [7:0] value;
    } cag_implied_t;
    typedef struct packed {
        logic valid;
        logic wide;
        logic [2:0] sel;
        logic [15:0] data;
    } cag_reg_write_t;
endpackage
`default_nettype wire

// *** verification/cag_table_model.sv ***
`default_nettype none
module cag_table_model (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_table_req,
    input wire logic [15:0] i_table_addr,
    input wire logic [3:0] i_delay,
    output logic o_table_valid,
    output logic [15:0] o_table_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // Each word is a fixed mix of its address so every entry differs from its neighbours.
    function automatic logic [15:0] entry(input logic [15:0] addr);
        return {addr[7:0], ~addr[7:0]} ^ 16'hA55A;
    endfunction
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wait_reg <= 4'h0;
            o_table_valid <= 1'b0;
            o_table_data <= 16'hFFFF;
        end else if (i_table_req && !o_table_valid && wait_reg == i_delay) begin
            o_table_valid <= 1'b1;
            o_table_data <= entry(i_table_addr);
        end else begin
            // Outside the answer cycle the data keeps toggling, so a stale read cannot pass.
            wait_reg <= (i_table_req && !o_table_valid) ? wait_reg + 4'h1 : 4'h0;
            o_table_valid <= 1'b0;
            o_table_data <= ~o_table_data;
        end
    end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cag_pkg::*;
    logic clk, rst_n, bsl, bsh, ready, treq, tvalid, opv;
    logic [15:0] taddr, tdata, pc;
    logic [7:0] acc;
    logic [3:0] delay;
    cag_branch_t br;
    cag_operand_t opr;
    cag_result_t res;
    cag_implied_t imp;
    cag_reg_write_t rw;
    int err_count, num_checks;

    cag_addr_gen dut (.i_clock(clk), .i_reset_n(rst_n), .i_bank_select_low(bsl),
        .i_bank_select_high(bsh), .i_branch(br), .o_branch_ready(ready), .o_table_req(treq),
        .o_table_addr(taddr), .i_table_valid(tvalid), .i_table_data(tdata),
        .o_program_counter(pc), .i_operand(opr), .o_operand_valid(opv),
        .o_operand_result(res), .i_implied(imp), .i_reg_write(rw), .o_accumulator(acc));
    cag_table_model table_mem (.i_clock(clk), .i_reset_n(rst_n), .i_table_req(treq),
        .i_table_addr(taddr), .i_delay(delay), .o_table_valid(tvalid), .o_table_data(tdata));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("Checks made %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Every driver task starts and ends just after a falling edge.
    task automatic do_branch(input cag_branch_kind_t k, input logic [2:0] n,
                             input logic [15:0] op);
        br = '{1'b1, k, n, op};
        @(negedge clk);
        br.valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic w, input logic [2:0] s, input logic [15:0] d);
        rw = '{1'b1, w, s, d};
        @(negedge clk);
        rw.valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic do_imp(input cag_implied_op_t o, input logic [2:0] s, input logic [7:0] v);
        imp = '{1'b1, o, s, v};
        @(negedge clk);
        imp.valid = 1'b0;
        @(negedge clk);
    endtask

    // The result pulse lasts one cycle, so it is judged at the first falling edge.
    task automatic op_chk(input cag_operand_mode_t m, input logic w, input logic [2:0] s,
                          input logic [15:0] op, input logic [15:0] ea,
                          input logic [15:0] ed, input logic ef);
        opr = '{1'b1, m, w, s, op};
        @(negedge clk);
        opr.valid = 1'b0;
        chk("operand valid", 16'h0001, {15'h0, opv});
        chk("operand addr", ea, res.addr);
        chk("operand data", ed, res.data);
        chk("operand fault", {15'h0, ef}, {15'h0, res.fault});
        chk("operand is_reg", {15'h0, (m == OP_IMPLIED || m == OP_REGISTER)},
            {15'h0, res.is_reg});
        @(negedge clk);
    endtask

    task automatic test_reset();
        chk("reset pc", 16'h0000, pc);
        chk("reset ready", 16'h0001, {15'h0, ready});
        chk("reset table req", 16'h0000, {15'h0, treq});
        chk("reset operand valid", 16'h0000, {15'h0, opv});
    endtask

    task automatic test_seq();
        logic [15:0] exp;
        exp = pc;
        for (int n = 1; n <= 7; n++) begin
            br = '{1'b1, BR_SEQ, 3'(n), 16'h0};
            @(negedge clk);
            exp = exp + 16'(n);
            chk("sequential pc", exp, pc);
        end
        br.valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic test_jumps();
        do_branch(BR_IMM16, 3'h3, 16'hFFF0);
        chk("immediate pc", 16'hFFF0, pc);
        do_branch(BR_REL, 3'h2, 16'hAB7F);
        chk("relative forward pc", 16'h0071, pc);
        do_branch(BR_REL, 3'h2, 16'h0080);
        chk("relative backward pc", 16'hFFF3, pc);
        do_branch(BR_IMM11, 3'h2, 16'hFFFF);
        chk("short call pc", 16'h07FF, pc);
    endtask

    task automatic test_table(input logic [3:0] dly, input logic [7:0] imm);
        logic [15:0] a;
        int n;
        a = {8'h0, imm & 8'h3E};
        delay = dly;
        br = '{1'b1, BR_TABLE, 3'h1, {8'h0, imm}};
        @(negedge clk);
        br = '{1'b1, BR_IMM16, 3'h3, 16'h8888};
        chk("table req", 16'h0001, {15'h0, treq});
        chk("ready while waiting", 16'h0000, {15'h0, ready});
        chk("table addr", a, taddr);
        n = 0;
        while (treq === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        br.valid = 1'b0;
        if (n >= 20) begin
            err_count++;
            results();
        end
        chk("table pc", {a[7:0], ~a[7:0]} ^ 16'hA55A, pc);
        @(negedge clk);
    endtask

    task automatic test_banks();
        {bsh, bsl} = 2'h2;
        wr(1'b1, 3'h0, 16'hC0DE);
        {bsh, bsl} = 2'h1;
        wr(1'b1, 3'h0, 16'h1357);
        do_branch(BR_REG, 3'h1, 16'h0);
        chk("register jump pc", 16'h1357, pc);
        {bsh, bsl} = 2'h2;
        do_branch(BR_REG, 3'h1, 16'h0);
        chk("bank two jump pc", 16'hC0DE, pc);
        op_chk(OP_REGISTER, 1'b0, A_IDX, 16'h0, 16'h0, 16'h00C0, 1'b0);
        op_chk(OP_REGISTER, 1'b0, X_IDX, 16'h0, 16'h0, 16'h00DE, 1'b0);
    endtask

    task automatic test_implied();
        wr(1'b0, A_IDX, 16'h00F3);
        wr(1'b0, 3'h3, 16'h0011);
        do_imp(IMP_MULTIPLY, 3'h3, 8'h00);
        op_chk(OP_REGISTER, 1'b1, 3'h0, 16'h0, 16'h0, 16'h1023, 1'b0);
        wr(1'b1, 3'h0, 16'h1234);
        wr(1'b0, 3'h2, 16'h0010);
        do_imp(IMP_DIVIDE, 3'h2, 8'h00);
        op_chk(OP_REGISTER, 1'b1, 3'h0, 16'h0, 16'h0, 16'h0123, 1'b0);
        op_chk(OP_REGISTER, 1'b0, 3'h2, 16'h0, 16'h0, 16'h0004, 1'b0);
        do_imp(IMP_ACCUM, 3'h0, 8'h5A);
        chk("accumulator", 16'h005A, {8'h0, acc});
        op_chk(OP_IMPLIED, 1'b0, 3'h0, 16'h0, 16'h0, 16'h005A, 1'b0);
        // Division by zero leaves all ones in the pair and the old low byte in the divisor.
        wr(1'b0, 3'h4, 16'h0000);
        do_imp(IMP_DIVIDE, 3'h4, 8'h00);
        op_chk(OP_IMPLIED, 1'b1, 3'h0, 16'h0, 16'h0, 16'hFFFF, 1'b0);
        op_chk(OP_REGISTER, 1'b0, 3'h4, 16'h0, 16'h0, 16'h0023, 1'b0);
        // An implied result and a port write in one cycle: the port write is dropped.
        rw = '{1'b1, 1'b0, 3'h5, 16'h0077};
        imp = '{1'b1, IMP_ACCUM, 3'h0, 8'h66};
        @(negedge clk);
        rw.valid = 1'b0;
        imp.valid = 1'b0;
        @(negedge clk);
        chk("accumulator over port write", 16'h0066, {8'h0, acc});
        op_chk(OP_REGISTER, 1'b0, 3'h5, 16'h0, 16'h0, 16'h0000, 1'b0);
    endtask

    task automatic test_memory_modes();
        {bsh, bsl} = 2'h3;
        wr(1'b1, 3'h2, 16'h8001);
        wr(1'b1, 3'h3, 16'hFFF0);
        op_chk(OP_DIRECT, 1'b0, 3'h0, 16'hFE00, 16'hFE00, 16'h0, 1'b0);
        op_chk(OP_SHORT, 1'b0, 3'h0, 16'h001F, 16'hFF1F, 16'h0, 1'b0);
        op_chk(OP_SHORT, 1'b0, 3'h0, 16'h0020, 16'hFE20, 16'h0, 1'b0);
        op_chk(OP_SHORT, 1'b0, 3'h0, 16'h00FF, 16'hFEFF, 16'h0, 1'b0);
        op_chk(OP_SHORT, 1'b0, 3'h0, 16'h0000, 16'hFF00, 16'h0, 1'b0);
        op_chk(OP_SHORT, 1'b1, 3'h0, 16'h0021, 16'hFE21, 16'h0, 1'b1);
        op_chk(OP_SHORT, 1'b1, 3'h0, 16'h0022, 16'hFE22, 16'h0, 1'b0);
        op_chk(OP_SFR, 1'b0, 3'h0, 16'h00CF, 16'hFFCF, 16'h0, 1'b0);
        op_chk(OP_SFR, 1'b0, 3'h0, 16'h00D0, 16'hFFD0, 16'h0, 1'b1);
        op_chk(OP_SFR, 1'b0, 3'h0, 16'h00E0, 16'hFFE0, 16'h0, 1'b0);
        op_chk(OP_SFR, 1'b1, 3'h0, 16'h00E1, 16'hFFE1, 16'h0, 1'b1);
        op_chk(OP_INDIRECT, 1'b0, 3'h2, 16'h0, 16'h8001, 16'h0, 1'b0);
        op_chk(OP_BASED, 1'b0, 3'h0, 16'h00F0, 16'h00E0, 16'h0, 1'b0);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        {bsh, bsl} = 2'h0;
        br = '0;
        opr = '0;
        imp = '0;
        rw = '0;
        delay = 4'h0;
        err_count = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        test_reset();
        test_seq();
        test_jumps();
        test_table(4'h0, 8'h3F);
        test_table(4'h5, 8'h02);
        test_banks();
        test_implied();
        test_memory_modes();
        results();
    end
endmodule
`default_nettype wire
